// ==== dv/pscr_core_test.sv ====
// Purpose: Self-checking bench for the power status and control bank.
// Assumes: Read data is compared on the falling edge after the edge that takes the read.
// Notes: Expected read bytes wait in a queue until the monitor sees the answer.
`default_nettype none
module pscr_core_test import pscr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, clk_en, pin, pfo_n, done, wr, rd, start, valid, shut, pend, pv;
  logic [1:0] st, raw, sv, band;
  logic [7:0] addr, wdata, rdata;
  logic [7:0] exp_q[$];
  integer bad_count, total_checks, seed, cyc_n, i, k;
  pscr_host host (.i_ref_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  pscr_core dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_clk_en(clk_en), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_rd_data(rdata),
    .i_push_button_pin(pin), .i_pwr_state(st), .i_powerfail_out_n(pfo_n),
    .i_coin_acq_done(done), .i_coin_band_raw(raw), .o_coin_acq_start(start),
    .o_coin_band_valid(valid), .o_rail_shutdown(shut));
  // Free-running reference clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Compares one byte and counts it.
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Compares one single-bit flag and counts it.
  task automatic cmp_flag(input string n, input logic e, input logic g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask
  // Prints the verdict and ends the run; a read note never answered counts as a mismatch.
  task automatic final_report;
    cmp("rd_pending", 8'h00, 8'(exp_q.size()));
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Notes the expected byte, then reads.
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.cyc(1'b0, a, 8'h00);
  endtask
  // Starts an acquisition and answers it after a random delay.
  task automatic acq(input logic [1:0] b);
    host.cyc(1'b1, 8'h06, 8'h01);
    for (k = 0; k < 4 && start !== 1'b1; k++) @(negedge clk);
    cmp_flag("acq_start", 1'b1, start);
    repeat (1 + ($unsigned($random(seed)) % 5)) @(posedge clk);
    done <= 1'b1;
    raw <= b;
    @(posedge clk);
    done <= 1'b0;
    band = b;
  endtask
  // Cycle ceiling and read-answer tracking.
  always @(posedge clk) begin
    pend <= rd & clk_en & rst_b;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      bad_count = bad_count + 1;
      final_report;
    end
  end
  // Takes the oldest note off the queue when a read answer is due.
  always @(negedge clk) begin
    if (pend && exp_q.size() > 0) begin
      cmp("rd_data", exp_q.pop_front(), rdata);
    end
  end
  // Main sequence.
  initial begin
    {rst_b, pin, st, pfo_n, done, raw, pend, cyc_n, bad_count, total_checks} = 0;
    {clk_en, pin, pfo_n} = 3'b111;
    band = 2'h0;
    seed = 46;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rdx(8'h06, 8'h00);
    rdx(8'h07, 8'h00);
    host.cyc(1'b1, 8'h06, 8'hfc);
    repeat (2) @(negedge clk);
    cmp_flag("acq_start", 1'b0, start);
    rdx(8'h06, 8'h00);
    @(posedge clk);
    done <= 1'b1;
    raw <= 2'h2;
    @(posedge clk);
    done <= 1'b0;
    for (i = 0; i < 8; i++) begin
      pv = $random(seed);
      sv = i[1:0];
      pin <= pv;
      st <= sv;
      rdx(8'h05, {3'b000, ~pv, sv, band});
    end
    @(negedge clk);
    cmp_flag("band_valid", 1'b0, valid);
    for (i = 0; i < 3; i++) begin
      acq(i[1:0]);
      rdx(8'h05, {3'b000, ~pin, st, band});
      cmp_flag("band_valid", 1'b1, valid);
    end
    pfo_n <= 1'b0;
    repeat (3) @(negedge clk);
    cmp_flag("shutdown", 1'b0, shut);
    host.cyc(1'b1, 8'h06, 8'h02);
    rdx(8'h06, 8'h02);
    cmp_flag("shutdown", 1'b1, shut);
    pfo_n <= 1'b1;
    repeat (2) @(negedge clk);
    cmp_flag("shutdown", 1'b0, shut);
    // Reset in mid-run with the enable set and the comparator tripped.
    @(posedge clk);
    pfo_n <= 1'b0;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    band = 2'h0;
    rdx(8'h06, 8'h00);
    cmp_flag("shutdown", 1'b0, shut);
    cmp_flag("band_valid", 1'b0, valid);
    rdx(8'h05, {3'b000, ~pin, st, band});
    // A write while the clock enable is low must leave the control register alone.
    clk_en <= 1'b0;
    host.cyc(1'b1, 8'h06, 8'h03);
    clk_en <= 1'b1;
    rdx(8'h06, 8'h00);
    cmp_flag("shutdown", 1'b0, shut);
    repeat (2) @(negedge clk);
    final_report;
  end
endmodule
`default_nettype wire

// ==== dv/pscr_host.sv ====
// Purpose: Host model that issues single-byte register cycles to the bank.
// Assumes: Each request changes just after a rising edge and is taken at the next one.
// Notes: Between cycles address and data show the inverse of the last value.
`default_nettype none
module pscr_host (
  // Clock.
  input wire logic i_ref_clk,
  // Register port.
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle levels from time zero.
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // One write or read strobe cycle, then release with stale values turned over.
  task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= w;
    o_rd <= ~w;
    @(posedge i_ref_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== hdl/pscr_acq.sv ====
// Purpose: Coin-cell acquisition sequencer; issues a start to the comparator and keeps the last band.
// Assumes: The analog side pulses i_done with i_band_raw valid in the same cycle.
// Notes: A trigger that arrives while an acquisition runs is ignored.
`include "pscr_regs.svh"
`default_nettype none
module pscr_acq
  import pscr_pkg::*;
(
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  // Trigger and analog result.
  input wire logic i_go,
  input wire logic i_done,
  input wire logic [1:0] i_band_raw,
  // Results.
  output logic o_start,
  output logic [1:0] o_band,
  output logic o_valid
);
  pscr_acq_e state;
  pscr_acq_e next_state;
  logic take_go;
  logic take_done;

  // Decode the two events that move the sequencer.
  assign take_go = (state == PSCR_ACQ_IDLE) && i_go;
  assign take_done = (state == PSCR_ACQ_BUSY) && i_done;

  // Next state selection.
  always_comb begin
    case (state)
      PSCR_ACQ_IDLE: next_state = take_go ? PSCR_ACQ_BUSY : PSCR_ACQ_IDLE;
      PSCR_ACQ_BUSY: next_state = take_done ? PSCR_ACQ_IDLE : PSCR_ACQ_BUSY;
      default: next_state = PSCR_ACQ_IDLE;
    endcase
  end

  // Sequencer registers; the band only changes when a conversion completes.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= PSCR_ACQ_IDLE;
      o_start <= 1'b0;
      o_band <= `PSCR_BAND_RESET;
      o_valid <= 1'b0;
    end else if (i_clk_en) begin
      state <= next_state;
      o_start <= take_go;
      if (take_done) begin
        o_band <= i_band_raw;
        o_valid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/pscr_core.sv ====
// Purpose: Host-visible status and control registers of the power management device.
// Assumes: The serial bus engine presents subaddress, strobes and data synchronous to i_ref_clk.
// Notes: Read data is registered one cycle after the read strobe; reads never change state.
// Summary of operation
// R01 - Status bit 4 reads 1 while the push-button pin is low and 0 while it is high.
// R02 - Status bits 3-2 report the power state: 0 transitional, 1 waiting for enable, 2 active, 3 suspend.
// R03 - Status bits 1-0 report the coin-cell band: 0 below low, 1 low to good, 2 good to ideal.
// R04 - Software runs an acquisition before trusting the coin-cell band.
// R05 - The control register sits at subaddress 0x06, resets to 0x00 and its bits 7-2 read zero.
// R06 - With the power-fail shutdown enable at 0 the comparator output has no effect on power state.
// R07 - With the enable at 1 a comparator trip shuts every rail down and enters the off state; o_rail_shutdown here follows the trip and drops when it clears.
// R08 - Writing 1 to bit 0 starts an acquisition and the bit clears itself; writing 0 does nothing.
// R09 - Reading status has no side effects and always mirrors the live pin, state and last result.
`include "pscr_regs.svh"
`default_nettype none
module pscr_core
  import pscr_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  // Register port from the serial bus engine.
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_rd_data,
  // Device status inputs.
  input wire logic i_push_button_pin,
  input wire logic [1:0] i_pwr_state,
  input wire logic i_powerfail_out_n,
  // Coin-cell comparator.
  input wire logic i_coin_acq_done,
  input wire logic [1:0] i_coin_band_raw,
  output logic o_coin_acq_start,
  output logic o_coin_band_valid,
  // Rail sequencer.
  output logic o_rail_shutdown
);
  logic powerfail_shutdown_en;
  logic coin_acquire_go;
  logic [1:0] coin_charge_band;
  logic wr_ctrl;
  logic go_write;
  logic next_go;
  logic [7:0] next_rd_data;
  pscr_status_s status_img;
  pscr_ctrl_s ctrl_img;
  pscr_status_s rd_status_view;
  pscr_ctrl_s rd_ctrl_view;

  // Read image selected by subaddress; unmapped addresses read zero.
  function automatic logic [7:0] rd_mux(input logic [7:0] addr, input pscr_status_s st, input pscr_ctrl_s ct);
    if (addr == `PSCR_ADDR_STATUS) begin
      rd_mux = st;
    end else if (addr == `PSCR_ADDR_CONTROL) begin
      rd_mux = ct;
    end else begin
      rd_mux = `PSCR_RD_UNMAPPED;
    end
  endfunction

  // Status image built from live inputs and the last acquisition result.
  assign status_img.pad = 3'h0;
  assign status_img.button_level = ~i_push_button_pin; // [R01]
  assign status_img.state = pscr_pwr_e'(i_pwr_state); // [R02]
  assign status_img.coin_charge_band = coin_charge_band; // [R03]
  assign ctrl_img.rsvd = `PSCR_RSVD_ZERO; // [R05]
  assign ctrl_img.powerfail_shutdown_en = powerfail_shutdown_en;
  assign ctrl_img.coin_acquire_go = coin_acquire_go;
  assign next_rd_data = rd_mux(i_reg_addr, status_img, ctrl_img); // [R09]

  // Write decode; a written 1 wins over the self-clear in the same cycle.
  assign wr_ctrl = i_reg_wr && (i_reg_addr == `PSCR_ADDR_CONTROL); // [R05]
  assign go_write = wr_ctrl && i_reg_wdata[`PSCR_BIT_ACQ];
  assign next_go = go_write; // [R08]

  // Control register, read data and rail shutdown request.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      powerfail_shutdown_en <= `PSCR_CTRL_RESET;
      coin_acquire_go <= `PSCR_CTRL_RESET;
      o_rd_data <= `PSCR_RD_RESET;
      o_rail_shutdown <= 1'b0;
    end else if (i_clk_en) begin
      if (wr_ctrl) begin
        powerfail_shutdown_en <= i_reg_wdata[`PSCR_BIT_PFEN];
      end
      coin_acquire_go <= next_go; // [R08]
      if (i_reg_rd) begin
        o_rd_data <= next_rd_data;
      end
      o_rail_shutdown <= powerfail_shutdown_en && !i_powerfail_out_n; // [R06] [R07]
    end
  end

  // Acquisition sequencer, started by the self-clearing go bit.
  pscr_acq u_acq (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en),
    .i_go(coin_acquire_go), // [R08]
    .i_done(i_coin_acq_done),
    .i_band_raw(i_coin_band_raw),
    .o_start(o_coin_acq_start),
    .o_band(coin_charge_band),
    .o_valid(o_coin_band_valid) // [R04]
  );

  // Checks on the register behaviour.
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  // Read data seen through the register layouts, so the state, band and control-image checks name fields rather than bit positions.
  assign rd_status_view = o_rd_data;
  assign rd_ctrl_view = o_rd_data;

  sequence s_rd_status;
    i_clk_en && i_reg_rd && (i_reg_addr == `PSCR_ADDR_STATUS);
  endsequence
  sequence s_rd_ctrl;
    i_clk_en && i_reg_rd && (i_reg_addr == `PSCR_ADDR_CONTROL);
  endsequence
  sequence s_go_write;
    i_clk_en && i_reg_wr && (i_reg_addr == `PSCR_ADDR_CONTROL) && i_reg_wdata[`PSCR_BIT_ACQ];
  endsequence
  sequence s_ctrl_write;
    i_clk_en && i_reg_wr && (i_reg_addr == `PSCR_ADDR_CONTROL);
  endsequence
  sequence s_wr_other;
    i_clk_en && i_reg_wr && (i_reg_addr != `PSCR_ADDR_CONTROL);
  endsequence
  sequence s_done_busy;
    i_clk_en && i_coin_acq_done && (u_acq.state == PSCR_ACQ_BUSY);
  endsequence

  property p_button;
    s_rd_status |=> o_rd_data[`PSCR_BIT_BUTTON] == !$past(i_push_button_pin);
  endproperty
  a_button: assert property (p_button) else $error("Button bit does not mirror the pin."); // [R01]

  property p_state;
    s_rd_status |=> rd_status_view.state == $past(i_pwr_state);
  endproperty
  a_state: assert property (p_state) else $error("State field does not mirror the machine."); // [R02]

  property p_band;
    s_rd_status |=> (rd_status_view.coin_charge_band == $past(coin_charge_band)) && (rd_status_view.pad == 3'h0);
  endproperty
  a_band: assert property (p_band) else $error("Band field does not mirror the last result."); // [R03]

  property p_rsvd;
    s_rd_ctrl |=> o_rd_data[`PSCR_RSVD_HI:`PSCR_RSVD_LO] == `PSCR_RSVD_ZERO;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("Reserved control bits read nonzero."); // [R05]

  property p_pf_off;
    (i_clk_en && !powerfail_shutdown_en) |=> !o_rail_shutdown;
  endproperty
  a_pf_off: assert property (p_pf_off) else $error("Shutdown raised while disabled."); // [R06]

  property p_pf_on;
    (i_clk_en && powerfail_shutdown_en && !i_powerfail_out_n) |=> o_rail_shutdown;
  endproperty
  a_pf_on: assert property (p_pf_on) else $error("Power-fail trip did not shut rails down."); // [R07]

  property p_go_start;
    s_go_write ##1 (i_clk_en && !go_write && (u_acq.state == PSCR_ACQ_IDLE)) |=> !coin_acquire_go && o_coin_acq_start;
  endproperty
  a_go_start: assert property (p_go_start) else $error("Acquisition not started or go not cleared."); // [R08]

  property p_go_clear;
    (i_clk_en && coin_acquire_go && !go_write) |=> !coin_acquire_go;
  endproperty
  a_go_clear: assert property (p_go_clear) else $error("Go bit did not clear itself."); // [R08]

  property p_go_zero;
    (i_clk_en && !go_write && !coin_acquire_go) |=> !coin_acquire_go ##0 !$rose(o_coin_acq_start);
  endproperty
  a_go_zero: assert property (p_go_zero) else $error("Writing zero had an effect."); // [R08]

  property p_rd_quiet;
    (i_clk_en && i_reg_rd && !i_reg_wr) |=> $stable(powerfail_shutdown_en);
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("A read changed control state."); // [R09]

  property p_rd_ctrl;
    s_rd_ctrl |=> (rd_ctrl_view.powerfail_shutdown_en == $past(powerfail_shutdown_en)) && (rd_ctrl_view.coin_acquire_go == $past(coin_acquire_go));
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("Control read image does not match the register."); // [R05]

  property p_wr_other;
    s_wr_other |=> $stable(powerfail_shutdown_en);
  endproperty
  a_wr_other: assert property (p_wr_other) else $error("A write elsewhere changed the control register."); // [R05]

  property p_pf_set;
    s_ctrl_write |=> powerfail_shutdown_en == $past(i_reg_wdata[`PSCR_BIT_PFEN]);
  endproperty
  a_pf_set: assert property (p_pf_set) else $error("Shutdown enable did not take the written value."); // [R06] [R07]

  property p_pf_clear;
    (i_clk_en && i_powerfail_out_n) |=> !o_rail_shutdown;
  endproperty
  a_pf_clear: assert property (p_pf_clear) else $error("Shutdown raised without a comparator trip."); // [R07]

  property p_start_once;
    (i_clk_en && o_coin_acq_start) |=> !o_coin_acq_start;
  endproperty
  a_start_once: assert property (p_start_once) else $error("Acquisition start lasted more than one cycle."); // [R08]

  property p_band_take;
    s_done_busy |=> (coin_charge_band == $past(i_coin_band_raw)) && o_coin_band_valid;
  endproperty
  a_band_take: assert property (p_band_take) else $error("Completed conversion did not update the band."); // [R03]

  property p_band_hold;
    (i_clk_en && !(i_coin_acq_done && (u_acq.state == PSCR_ACQ_BUSY))) |=> $stable(coin_charge_band);
  endproperty
  a_band_hold: assert property (p_band_hold) else $error("Band changed without a completed conversion."); // [R03]

  property p_rd_hold;
    !(i_clk_en && i_reg_rd) |=> $stable(o_rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("Read data changed without a read."); // [R09]
endmodule
`default_nettype wire

// ==== hdl/pscr_pkg.sv ====
// Purpose: Types shared by the power status and control bank.
// Assumes: Nothing beyond the register header.
// Notes: The status layout matches the read image of the status register.
`default_nettype none
package pscr_pkg;
  // Power state machine codes as reported in the status register.
  typedef enum logic [1:0] {
    PSCR_TRANSITIONAL = 2'b00,
    PSCR_WAIT_POWER_ENABLE = 2'b01,
    PSCR_ACTIVE = 2'b10,
    PSCR_SUSPEND = 2'b11
  } pscr_pwr_e;
  // Coin-cell acquisition sequencer states.
  typedef enum logic {
    PSCR_ACQ_IDLE = 1'b0,
    PSCR_ACQ_BUSY = 1'b1
  } pscr_acq_e;
  // Read image of the status register.
  typedef struct packed {
    logic [2:0] pad;
    logic button_level;
    pscr_pwr_e state;
    logic [1:0] coin_charge_band;
  } pscr_status_s;
  // Read image of the control register.
  typedef struct packed {
    logic [5:0] rsvd;
    logic powerfail_shutdown_en;
    logic coin_acquire_go;
  } pscr_ctrl_s;
endpackage
`default_nettype wire

// ==== hdl/pscr_regs.svh ====
// Purpose: Register addresses, bit positions and reset values of the power status and control bank.
// Assumes: 8-bit subaddresses and 8-bit register data.
// Notes: Definitions only.
`ifndef PSCR_REGS_SVH
`define PSCR_REGS_SVH
`define PSCR_ADDR_STATUS 8'h05
`define PSCR_ADDR_CONTROL 8'h06
`define PSCR_CTRL_RESET 1'b0
`define PSCR_BIT_ACQ 0
`define PSCR_BIT_PFEN 1
`define PSCR_BIT_BUTTON 4
`define PSCR_RSVD_HI 7
`define PSCR_RSVD_LO 2
`define PSCR_RSVD_ZERO 6'h00
`define PSCR_RD_UNMAPPED 8'h00
`define PSCR_RD_RESET 8'h00
`define PSCR_BAND_RESET 2'h0
`endif
